// ### hw/aszr_top.sv
/*
   Angle sensor readout: phase counting angle converter, zero offset,
   serial mode 3 slave with register write and read, fuse store control.
   Assumes an external fuse macro that presents its stored value on pins and
   burns FUSE_DATA_O while FUSE_PROGRAM_O is high; SCLK_I comes from the master.
*/
`timescale 1ns/1ps
`include "aszr_defines.svh"

module aszr_top
   import aszr_pkg::*;
#(
   parameter int FIFO_DEPTH       = `ASZR_FIFO_DEPTH,
   parameter int FUSE_PROG_CYCLES = `ASZR_FUSE_PROG_CYCLES
) (
   input  wire logic        SYS_CLK_I,
   input  wire logic        RESET_N_I,
   input  wire logic        SCLK_I,
   input  wire logic        CS_N_I,
   input  wire logic        MOSI_I,
   output logic             MISO_O,
   input  wire logic        PHASE_I,
   input  wire logic        FUSE_BURNT_I,
   input  wire logic [7:0]  FUSE_VALUE_I,
   output logic             FUSE_PROGRAM_O,
   output logic [7:0]       FUSE_DATA_O
);

   localparam int          PW          = $clog2(FUSE_PROG_CYCLES + 1);
   localparam logic [7:0]  SAMPLE_LAST = 8'(`ASZR_SAMPLE_CYCLES - 1);
   localparam logic [15:0] SAMPLE_DIV  = 16'(`ASZR_SAMPLE_CYCLES);

   // Synchronisers for pins and for the frame toggle from the link domain.
   logic        cs_meta;
   logic        cs_sync;
   logic        phase_meta;
   logic        phase_sync;
   logic        phase_last;
   logic        tog_meta;
   logic        tog_sync;
   logic        tog_last;
   logic        fb_meta;
   logic        fb_sync;
   logic [7:0]  fv_meta;
   logic [7:0]  fv_sync;

   // Front end and sample path.
   aszr_angle_t ref_cnt;
   aszr_angle_t tdc_cnt;
   logic        smp_valid;
   aszr_angle_t smp_data;
   aszr_angle_t out_raw;
   aszr_angle_t next_ref_cnt;
   aszr_angle_t next_tdc_cnt;
   logic        next_smp_valid;
   aszr_angle_t next_smp_data;
   aszr_angle_t next_out_raw;
   logic        fifo_in_ready;
   logic        fifo_out_valid;
   aszr_angle_t fifo_out_data;
   logic [15:0] tdc_scaled;

   // Register and fuse control.
   aszr_state_t state;
   aszr_angle_t zero_offset;
   logic        locked;
   logic [1:0]  load_cnt;
   logic [PW-1:0] prog_cnt;
   aszr_state_t next_state;
   aszr_angle_t next_zero_offset;
   logic        next_locked;
   logic [1:0]  next_load_cnt;
   logic [PW-1:0] next_prog_cnt;
   logic        next_fuse_program;
   aszr_angle_t next_fuse_data;
   logic        cmd_strobe;

   // Link domain.
   logic        link_rst_n;
   logic [3:0]  rx_cnt;
   aszr_word_t  rx_shift;
   aszr_word_t  frame_word;
   logic        frame_tog;
   logic [3:0]  tx_cnt;
   logic [6:0]  tx_shift;
   logic [3:0]  next_rx_cnt;
   aszr_word_t  next_rx_shift;
   aszr_word_t  next_frame_word;
   logic        next_frame_tog;
   logic [3:0]  next_tx_cnt;
   logic [6:0]  next_tx_shift;
   logic        next_miso;
   aszr_angle_t tx_load;
   aszr_angle_t reg_data;
   aszr_angle_t angle_out;

   always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         cs_meta    <= 1'b1;
         cs_sync    <= 1'b1;
         phase_meta <= 1'b0;
         phase_sync <= 1'b0;
         phase_last <= 1'b0;
         tog_meta   <= 1'b0;
         tog_sync   <= 1'b0;
         tog_last   <= 1'b0;
         fb_meta    <= 1'b0;
         fb_sync    <= 1'b0;
         fv_meta    <= 8'h00;
         fv_sync    <= 8'h00;
      end else begin
         cs_meta    <= CS_N_I;
         cs_sync    <= cs_meta;
         phase_meta <= PHASE_I;
         phase_sync <= phase_meta;
         phase_last <= phase_sync;
         tog_meta   <= frame_tog;
         tog_sync   <= tog_meta;
         tog_last   <= tog_sync;
         fb_meta    <= FUSE_BURNT_I;
         fb_sync    <= fb_meta;
         fv_meta    <= FUSE_VALUE_I;
         fv_sync    <= fv_meta;
      end
   end

   assign tdc_scaled = ({8'h00, tdc_cnt} * 16'(`ASZR_ANGLE_STEPS)) / SAMPLE_DIV;

   always_comb begin
      next_ref_cnt   = (ref_cnt == SAMPLE_LAST) ? 8'h00 : ref_cnt + 8'h01;
      next_tdc_cnt   = tdc_cnt;
      next_smp_valid = smp_valid;
      next_smp_data  = smp_data;
      next_out_raw   = out_raw;
      if (phase_sync && !phase_last) begin
         next_tdc_cnt = 8'h00;
      end else if (tdc_cnt != SAMPLE_LAST) begin
         next_tdc_cnt = tdc_cnt + 8'h01;
      end
      if (smp_valid && fifo_in_ready) begin
         next_smp_valid = 1'b0;
      end
      // A pending sample stalls the converter output until the FIFO takes it.
      if (ref_cnt == SAMPLE_LAST && !(smp_valid && !fifo_in_ready)) begin
         next_smp_valid = 1'b1;
         next_smp_data  = tdc_scaled[7:0];
      end
      if (fifo_out_valid && cs_sync) begin
         next_out_raw = fifo_out_data;
      end
   end

   always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         ref_cnt   <= 8'h00;
         tdc_cnt   <= 8'h00;
         smp_valid <= 1'b0;
         smp_data  <= 8'h00;
         out_raw   <= 8'h00;
      end else begin
         ref_cnt   <= next_ref_cnt;
         tdc_cnt   <= next_tdc_cnt;
         smp_valid <= next_smp_valid;
         smp_data  <= next_smp_data;
         out_raw   <= next_out_raw;
      end
   end

   aszr_fifo #(
      .WIDTH (8),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clk_i       (SYS_CLK_I),
      .rst_n_i     (RESET_N_I),
      .in_valid_i  (smp_valid),
      .in_data_i   (smp_data),
      .in_ready_o  (fifo_in_ready),
      .out_valid_o (fifo_out_valid),
      .out_data_o  (fifo_out_data),
      .out_ready_i (cs_sync)
   );

   assign cmd_strobe = tog_sync ^ tog_last;

   always_comb begin
      next_state        = state;
      next_zero_offset  = zero_offset;
      next_locked       = locked;
      next_load_cnt     = load_cnt;
      next_prog_cnt     = prog_cnt;
      next_fuse_program = FUSE_PROGRAM_O;
      next_fuse_data    = FUSE_DATA_O;
      case (state)
         ST_LOAD: begin
            next_load_cnt = load_cnt + 2'h1;
            if (load_cnt == `ASZR_FUSE_SYNC_CYCLES) begin
               next_zero_offset = fb_sync ? fv_sync : `ASZR_ZERO_RESET;
               next_locked      = fb_sync;
               next_state       = ST_RUN;
            end
         end
         ST_RUN: begin
            if (cmd_strobe && frame_word[15:12] == `ASZR_CMD_WRITE && !locked) begin
               if (frame_word[11:8] == `ASZR_ADDR_ZERO) begin
                  next_zero_offset = frame_word[7:0];
               end
               if (frame_word[11:8] == `ASZR_ADDR_FUSE &&
                   frame_word[`ASZR_FUSE_TRIG_BIT]) begin
                  next_state        = ST_BURN;
                  next_prog_cnt     = '0;
                  next_fuse_program = 1'b1;
                  next_fuse_data    = zero_offset;
               end
            end
         end
         ST_BURN: begin
            next_prog_cnt = prog_cnt + 1'b1;
            if (prog_cnt == PW'(FUSE_PROG_CYCLES - 1)) begin
               next_fuse_program = 1'b0;
               next_locked       = 1'b1;
               next_state        = ST_RUN;
            end
         end
         default: begin
            next_state = ST_LOAD;
         end
      endcase
   end

   always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         state          <= ST_LOAD;
         zero_offset    <= `ASZR_ZERO_RESET;
         locked         <= 1'b0;
         load_cnt       <= 2'h0;
         prog_cnt       <= '0;
         FUSE_PROGRAM_O <= 1'b0;
         FUSE_DATA_O    <= 8'h00;
      end else begin
         state          <= next_state;
         zero_offset    <= next_zero_offset;
         locked         <= next_locked;
         load_cnt       <= next_load_cnt;
         prog_cnt       <= next_prog_cnt;
         FUSE_PROGRAM_O <= next_fuse_program;
         FUSE_DATA_O    <= next_fuse_data;
      end
   end

   // Angles read by the link stay still during a frame without writes: the angle buffer is
   // frozen while select is low and the zero offset changes only after a 16-bit write word ends.
   assign angle_out = out_raw - zero_offset;
   assign link_rst_n = RESET_N_I & ~CS_N_I;

   always_comb begin
      case (rx_shift[3:0])
         `ASZR_ADDR_ZERO: reg_data = zero_offset;
         `ASZR_ADDR_FUSE: reg_data = {3'h0, FUSE_PROGRAM_O, 4'h0};
         default:         reg_data = 8'h00;
      endcase
   end

   always_comb begin
      next_rx_cnt     = rx_cnt + 4'h1;
      next_rx_shift   = {rx_shift[14:0], MOSI_I};
      next_frame_word = frame_word;
      next_frame_tog  = frame_tog;
      if (rx_cnt == 4'hf) begin
         next_frame_word = next_rx_shift;
         next_frame_tog  = ~frame_tog;
      end
   end

   always_ff @(posedge SCLK_I or negedge link_rst_n) begin
      if (!link_rst_n) begin
         rx_cnt   <= 4'h0;
         rx_shift <= 16'h0000;
      end else begin
         rx_cnt   <= next_rx_cnt;
         rx_shift <= next_rx_shift;
      end
   end

   always_ff @(posedge SCLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         frame_word <= 16'h0000;
         frame_tog  <= 1'b0;
      end else begin
         frame_word <= next_frame_word;
         frame_tog  <= next_frame_tog;
      end
   end

   always_comb begin
      tx_load = angle_out;
      if (tx_cnt == 4'h8 && rx_shift[7:4] == `ASZR_CMD_READ) begin
         tx_load = reg_data;
      end
      next_tx_cnt = tx_cnt + 4'h1;
      if (tx_cnt == 4'h0 || tx_cnt == 4'h8) begin
         next_miso     = tx_load[7];
         next_tx_shift = tx_load[6:0];
      end else begin
         next_miso     = tx_shift[6];
         next_tx_shift = {tx_shift[5:0], 1'b0};
      end
   end

   always_ff @(negedge SCLK_I or negedge link_rst_n) begin
      if (!link_rst_n) begin
         tx_cnt   <= 4'h0;
         tx_shift <= 7'h00;
         MISO_O   <= 1'b0;
      end else begin
         tx_cnt   <= next_tx_cnt;
         tx_shift <= next_tx_shift;
         MISO_O   <= next_miso;
      end
   end

endmodule

// ### hw/aszr_defines.svh
/*
   Constants of the angle sensor readout block: offsets, field positions,
   reset values and timing counts.
   Assumes it is included by its bare name before the modules that use it.
*/
`ifndef ASZR_DEFINES_SVH
`define ASZR_DEFINES_SVH

`define ASZR_SYS_CLK_HZ          100000000
`define ASZR_SYS_CLK_PERIOD_NS   10
`define ASZR_SAMPLE_RATE_HZ      500000
`define ASZR_SAMPLE_CYCLES       (`ASZR_SYS_CLK_HZ / `ASZR_SAMPLE_RATE_HZ)
`define ASZR_FUSE_PROG_TIME_NS   2600000
`define ASZR_FUSE_PROG_CYCLES    \
   ((`ASZR_FUSE_PROG_TIME_NS + `ASZR_SYS_CLK_PERIOD_NS - 1) / `ASZR_SYS_CLK_PERIOD_NS)
`define ASZR_ANGLE_STEPS         256
`define ASZR_CMD_READ            4'h1
`define ASZR_CMD_WRITE           4'h2
`define ASZR_ADDR_ZERO           4'h4
`define ASZR_ADDR_FUSE           4'h9
`define ASZR_FUSE_TRIG_BIT       4
`define ASZR_ZERO_RESET          8'h00
`define ASZR_FIFO_DEPTH          32
`define ASZR_FUSE_SYNC_CYCLES    2'h3

`endif

// ### hw/aszr_pkg.sv
/*
   Types shared by the angle sensor readout block.
   Assumes nothing of its surroundings.
*/
package aszr_pkg;

   typedef logic [7:0]  aszr_angle_t;
   typedef logic [15:0] aszr_word_t;

   typedef enum logic [1:0] {
      ST_LOAD,
      ST_RUN,
      ST_BURN
   } aszr_state_t;

endpackage

// ### hw/aszr_fifo.sv
/*
   Single clock FIFO built from flip-flops with valid and ready on both sides.
   Assumes both sides run on the same clock and reset.
*/
`timescale 1ns/1ps

module aszr_fifo
   import aszr_pkg::*;
#(
   parameter int WIDTH = 8,
   parameter int DEPTH = 32
) (
   input  wire logic             clk_i,
   input  wire logic             rst_n_i,
   input  wire logic             in_valid_i,
   input  wire logic [WIDTH-1:0] in_data_i,
   output logic                  in_ready_o,
   output logic                  out_valid_o,
   output logic [WIDTH-1:0]      out_data_o,
   input  wire logic             out_ready_i
);

   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr;
   logic [AW-1:0]    rd_ptr;
   logic [AW:0]      count;
   logic [AW-1:0]    next_wr_ptr;
   logic [AW-1:0]    next_rd_ptr;
   logic [AW:0]      next_count;
   logic             push;
   logic             pop;

   assign in_ready_o  = (count != (AW+1)'(DEPTH));
   assign out_valid_o = (count != '0);
   assign out_data_o  = mem[rd_ptr];

   always_comb begin
      push        = in_valid_i && in_ready_o;
      pop         = out_valid_o && out_ready_i;
      next_wr_ptr = wr_ptr;
      next_rd_ptr = rd_ptr;
      next_count  = count;
      if (push) begin
         next_wr_ptr = (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
         next_rd_ptr = (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
      end
      if (push && !pop) begin
         next_count = count + 1'b1;
      end else if (pop && !push) begin
         next_count = count - 1'b1;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count  <= '0;
      end else begin
         wr_ptr <= next_wr_ptr;
         rd_ptr <= next_rd_ptr;
         count  <= next_count;
      end
   end

   always_ff @(posedge clk_i) begin
      if (push) begin
         mem[wr_ptr] <= in_data_i;
      end
   end

endmodule

// ### testbench/aszr_spi_master.sv
/*
   Serial master model for the angle sensor readout: mode 3 frames on request.
   Assumes the bench calls xfer from one process at a time.
*/
`timescale 1ns/1ps

module aszr_spi_master (
   output logic      sclk_o,
   output logic      cs_n_o,
   output logic      mosi_o,
   input  wire logic miso_i
);
   initial begin
      sclk_o = 1'b1;
      cs_n_o = 1'b1;
      mosi_o = 1'b0;
   end

   // Sends nbits of tx MSB first and returns what came back on miso_i.
   // After every full byte but the last the clock rests high for pause ns.
   task automatic xfer(input logic [31:0] tx, input int nbits, input int hp,
                       input int pause, output logic [31:0] rx);
      rx = 32'h0;
      cs_n_o = 1'b0;
      #50;
      for (int i = nbits - 1; i >= 0; i--) begin
         sclk_o = 1'b0;
         mosi_o = tx[i];
         #(hp);
         sclk_o = 1'b1;
         rx = {rx[30:0], miso_i};
         #(hp);
         if (i % 8 == 0 && i != 0) begin
            #(pause);
         end
      end
      #25;
      cs_n_o = 1'b1;
      mosi_o = ~mosi_o;
      #50;
   endtask
endmodule

// ### testbench/aszr_top_asserts.sv
/*
   Port checker of the angle sensor readout: serial words and fuse store pulse.
   Assumes it is attached to aszr_top by the bind at the foot of this file.
*/
`timescale 1ns/1ps

module aszr_top_asserts
   import aszr_pkg::*;
#(
   parameter int FIFO_DEPTH       = 32,
   parameter int FUSE_PROG_CYCLES = 20
) (
   input wire logic       SYS_CLK_I,
   input wire logic       RESET_N_I,
   input wire logic       SCLK_I,
   input wire logic       CS_N_I,
   input wire logic       MOSI_I,
   input wire logic       MISO_O,
   input wire logic       PHASE_I,
   input wire logic       FUSE_BURNT_I,
   input wire logic [7:0] FUSE_VALUE_I,
   input wire logic       FUSE_PROGRAM_O,
   input wire logic [7:0] FUSE_DATA_O
);
   logic [5:0]  cnt, next_cnt;
   logic [15:0] sh_in, next_sh_in, sh_out, next_sh_out;
   logic [7:0]  first_ang, next_first_ang, wr_val, next_wr_val;
   logic        trig, next_trig, burned, next_burned;
   logic [31:0] hi_cnt, next_hi_cnt;

   // Shifts the current frame; cleared while chip select is high.
   always_comb begin
      next_cnt       = cnt + 6'h01;
      next_sh_in     = {sh_in[14:0], MOSI_I};
      next_sh_out    = {sh_out[14:0], MISO_O};
      next_first_ang = (cnt == 6'h07) ? next_sh_out[7:0] : first_ang;
   end
   always_ff @(posedge SCLK_I or posedge CS_N_I or negedge RESET_N_I) begin
      if (!RESET_N_I || CS_N_I) begin
         cnt       <= 6'h00;
         sh_in     <= 16'h0000;
         sh_out    <= 16'h0000;
         first_ang <= 8'h00;
      end else begin
         cnt       <= next_cnt;
         sh_in     <= next_sh_in;
         sh_out    <= next_sh_out;
         first_ang <= next_first_ang;
      end
   end

   // Remembers the last offset written and whether a store was triggered.
   always_comb begin
      next_wr_val = wr_val;
      next_trig   = trig;
      if (cnt[3:0] == 4'hf && next_sh_in[15:8] == 8'h24) begin
         next_wr_val = next_sh_in[7:0];
      end
      if (cnt[3:0] == 4'hf && next_sh_in[15:8] == 8'h29 && next_sh_in[4]) begin
         next_trig = 1'b1;
      end
   end
   always_ff @(posedge SCLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         wr_val <= 8'h00;
         trig   <= 1'b0;
      end else begin
         wr_val <= next_wr_val;
         trig   <= next_trig;
      end
   end

   // Measures the store pulse and notes that one has ended.
   always_comb begin
      next_hi_cnt = FUSE_PROGRAM_O ? hi_cnt + 32'h1 : 32'h0;
      next_burned = burned || (hi_cnt != 32'h0 && !FUSE_PROGRAM_O);
   end
   always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         hi_cnt <= 32'h0;
         burned <= 1'b0;
      end else begin
         hi_cnt <= next_hi_cnt;
         burned <= next_burned;
      end
   end

   sequence burn_start;
      $rose(FUSE_PROGRAM_O);
   endsequence
   sequence word_end;
      cnt[3:0] == 4'hf;
   endsequence

   chk_word_pair: assert property (@(posedge SCLK_I) disable iff (!RESET_N_I || CS_N_I)
      word_end ##0 (next_sh_in[15:12] != 4'h1) |-> next_sh_out[15:8] == next_sh_out[7:0])
      else $error("serial word bytes differ outside a read");
   chk_angle_frozen: assert property (@(posedge SCLK_I) disable iff (!RESET_N_I || CS_N_I)
      (cnt[2:0] == 3'h7) && (cnt[5:3] != 3'h0) && !(cnt[3] && next_sh_in[15:12] == 4'h1)
      |-> next_sh_out[7:0] == first_ang)
      else $error("angle changed inside one frame");
   chk_burn_length: assert property (@(posedge SYS_CLK_I) disable iff (!RESET_N_I)
      $fell(FUSE_PROGRAM_O) |-> hi_cnt == FUSE_PROG_CYCLES)
      else $error("store pulse has the wrong length");
   chk_burn_bound: assert property (@(posedge SYS_CLK_I) disable iff (!RESET_N_I)
      FUSE_PROGRAM_O |-> hi_cnt < FUSE_PROG_CYCLES)
      else $error("store pulse runs too long");
   chk_data_hold: assert property (@(posedge SYS_CLK_I) disable iff (!RESET_N_I)
      FUSE_PROGRAM_O && $past(FUSE_PROGRAM_O) |-> $stable(FUSE_DATA_O))
      else $error("store data moved during the pulse");
   chk_burn_data: assert property (@(posedge SYS_CLK_I) disable iff (!RESET_N_I)
      burn_start |-> FUSE_DATA_O == wr_val)
      else $error("stored value is not the zero offset");
   chk_burn_cause: assert property (@(posedge SYS_CLK_I) disable iff (!RESET_N_I)
      burn_start |-> trig)
      else $error("store pulse without a trigger word");
   chk_single_burn: assert property (@(posedge SYS_CLK_I) disable iff (!RESET_N_I)
      burned |-> !FUSE_PROGRAM_O)
      else $error("second store of a locked register");
   chk_locked_fuse: assert property (@(posedge SYS_CLK_I) disable iff (!RESET_N_I)
      FUSE_BURNT_I |-> !FUSE_PROGRAM_O)
      else $error("store pulse while fuses hold a value");
   chk_miso_idle: assert property (@(posedge SYS_CLK_I) disable iff (!RESET_N_I)
      CS_N_I && $past(CS_N_I) |-> !MISO_O)
      else $error("serial output active while deselected");
endmodule

bind aszr_top aszr_top_asserts #(
   .FIFO_DEPTH       (FIFO_DEPTH),
   .FUSE_PROG_CYCLES (FUSE_PROG_CYCLES)
) i_aszr_top_asserts (
   .SYS_CLK_I      (SYS_CLK_I),
   .RESET_N_I      (RESET_N_I),
   .SCLK_I         (SCLK_I),
   .CS_N_I         (CS_N_I),
   .MOSI_I         (MOSI_I),
   .MISO_O         (MISO_O),
   .PHASE_I        (PHASE_I),
   .FUSE_BURNT_I   (FUSE_BURNT_I),
   .FUSE_VALUE_I   (FUSE_VALUE_I),
   .FUSE_PROGRAM_O (FUSE_PROGRAM_O),
   .FUSE_DATA_O    (FUSE_DATA_O)
);

// ### testbench/tb_top.sv
/*
   Self-checking bench of the angle sensor readout through its serial port.
   Assumes the serial master model and the port checker are compiled first.
*/
`timescale 1ns/1ps

module tb_top
   import aszr_pkg::*;
;
   localparam int PROG = 60;
   logic        sys_clk = 1'b0;
   logic        reset_n = 1'b0;
   logic        phase = 1'b0;
   int          shift_req = 0;
   int          shift_done = 0;
   logic        fuse_burnt = 1'b0;
   logic [7:0]  fuse_value = 8'h00;
   logic        sclk, cs_n, mosi, miso, fuse_program;
   logic [7:0]  fuse_data;
   logic [31:0] rx32;
   aszr_angle_t a0;
   aszr_angle_t offs [3] = '{8'h24, 8'hf0, 8'h01};
   int          fail_count = 0;
   int          tests_run = 0;

   always #5 sys_clk = ~sys_clk;
   // Phase edges every 100 cycles, rising edges every 200; each shift request delays them once by 50 cycles.
   always begin
      #1000;
      if (shift_done != shift_req) begin
         #500;
         shift_done++;
      end
      phase = ~phase;
   end

   aszr_spi_master i_aszr_spi_master (
      .sclk_o (sclk),
      .cs_n_o (cs_n),
      .mosi_o (mosi),
      .miso_i (miso)
   );

   aszr_top #(
      .FIFO_DEPTH       (32),
      .FUSE_PROG_CYCLES (PROG)
   ) i_aszr_top (
      .SYS_CLK_I      (sys_clk),
      .RESET_N_I      (reset_n),
      .SCLK_I         (sclk),
      .CS_N_I         (cs_n),
      .MOSI_I         (mosi),
      .MISO_O         (miso),
      .PHASE_I        (phase),
      .FUSE_BURNT_I   (fuse_burnt),
      .FUSE_VALUE_I   (fuse_value),
      .FUSE_PROGRAM_O (fuse_program),
      .FUSE_DATA_O    (fuse_data)
   );

   task automatic print_verdict();
      $display("comparisons %0d, mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp) begin
         fail_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic xf(input logic [31:0] tx, input int n = 16, input int pause = 0);
      @(posedge sys_clk);
      #1;
      i_aszr_spi_master.xfer(tx, n, 3, pause, rx32);
   endtask

   task automatic wr_reg(input logic [3:0] addr, input logic [7:0] val);
      xf({16'h0000, 4'h2, addr, val});
   endtask

   task automatic rd_reg(input logic [3:0] addr);
      xf({16'h0000, 4'h1, addr, 8'h00});
   endtask

   task automatic do_reset(input logic burnt, input logic [7:0] val);
      @(posedge sys_clk);
      #1;
      reset_n = 1'b0;
      fuse_burnt = burnt;
      fuse_value = val;
      repeat (6) @(posedge sys_clk);
      #1;
      reset_n = 1'b1;
      repeat (600) @(posedge sys_clk);
   endtask

   task automatic wait_burn();
      int k;
      k = 0;
      while (fuse_program === 1'b1 && k < 4 * PROG) begin
         @(posedge sys_clk);
         k++;
      end
      if (k == 4 * PROG) begin
         fail_count++;
      end
   endtask

   initial begin
      do_reset(1'b0, 8'ha5);
      rd_reg(4'h4);
      chk8(rx32[7:0], 8'h00);
      a0 = rx32[15:8];
      foreach (offs[i]) begin
         wr_reg(4'h4, offs[i]);
         rd_reg(4'h4);
         chk8(rx32[7:0], offs[i]);
         chk8(rx32[15:8], a0 - offs[i]);
      end
      xf(32'h3455);
      wr_reg(4'h5, 8'h77);
      rd_reg(4'h5);
      chk8(rx32[7:0], 8'h00);
      rd_reg(4'h4);
      chk8(rx32[7:0], 8'h01);
      shift_req++;
      repeat (800) @(posedge sys_clk);
      a0 = a0 - 8'h40;
      rd_reg(4'h4);
      chk8(rx32[15:8], a0 - 8'h01);
      // The angle moves while this long frame is open; the buffer must not.
      shift_req++;
      xf(32'h00000000, 32, 2000);
      chk8(rx32[31:24], a0 - 8'h01);
      chk8(rx32[7:0], a0 - 8'h01);
      a0 = a0 - 8'h40;
      rd_reg(4'h4);
      chk8(rx32[15:8], a0 - 8'h01);
      wr_reg(4'h4, 8'h37);
      wr_reg(4'h9, 8'h10);
      chk8({7'h00, fuse_program}, 8'h01);
      chk8(fuse_data, 8'h37);
      rd_reg(4'h9);
      chk8({7'h00, rx32[4]}, 8'h01);
      wait_burn();
      wr_reg(4'h4, 8'h11);
      rd_reg(4'h4);
      chk8(rx32[7:0], 8'h37);
      wr_reg(4'h9, 8'h10);
      repeat (10) @(posedge sys_clk);
      chk8({7'h00, fuse_program}, 8'h00);
      do_reset(1'b1, 8'h5a);
      rd_reg(4'h4);
      chk8(rx32[7:0], 8'h5a);
      wr_reg(4'h4, 8'h01);
      rd_reg(4'h4);
      chk8(rx32[7:0], 8'h5a);
      print_verdict();
   end
endmodule
